// ===== inc/shp_pkg.sv
// Package of constants and types for the host bus port
// How it works
// - Interrupt output follows any active internal source
// - Read strobe drives selected register onto bus
// - Write strobe stores bus data into register
// - Two high address bits select register; A1 also in 16-bit mode, A1/A0 also in 8-bit mode
// - Shared pins: lane 2/3 enables or A0/A1
// - Lane0/upper enable honoured only in 32/16 modes
// - 16-bit A0/UBE decode; both high prohibited
// - Strobes ignored unless chip select or DMA grant active
// - 32-bit lane mapping onto bytes, one enable per lane
// - One parity bit per byte lane
// - 16-bit uses parity 0,1; others undriven
// - DMA grant forces data FIFO register access
package shp_pkg;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int REG_SEL_W = 4;
  localparam int NUM_REGS = 16;
  localparam int SRC_W = 8;
  localparam logic [3:0] FIFO_REG_IDX = 4'h0;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [1:0] MODE_8 = 2'h0;
  localparam logic [1:0] MODE_16 = 2'h1;
  localparam logic [1:0] MODE_32 = 2'h2;
  typedef enum logic [1:0] {
    SHP_IDLE = 2'b00,
    SHP_READ = 2'b01,
    SHP_WRITE = 2'b10
  } shp_state_t;
endpackage

// ===== inc/shp_mem_if.sv
// Interface between port logic and register storage
`timescale 1ns/1ps
interface shp_mem_if;
  logic [3:0] addr;
  logic [3:0] wrLane;
  logic [31:0] wrData;
  logic [31:0] rdData;
  modport port (output addr, output wrLane, output wrData, input rdData);
  modport mem (input addr, input wrLane, input wrData, output rdData);
endinterface

// ===== hw/shp_reg_mem.sv
// Register storage with registered read data
`timescale 1ns/1ps
module shp_reg_mem (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Access side
  shp_mem_if.mem bus
);
  typedef struct packed {
    logic [shp_pkg::NUM_REGS-1:0][31:0] regs;
    logic [31:0] rd;
  } shp_mem_st_t;
  shp_mem_st_t memReg;
  shp_mem_st_t memNext;
  always_comb begin
    memNext = memReg;
    for (int l = 0; l < shp_pkg::LANES; l++) begin
      if (bus.wrLane[l]) begin
        memNext.regs[bus.addr][l*8 +: 8] = bus.wrData[l*8 +: 8];
      end
    end
    memNext.rd = memReg.regs[bus.addr];
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      memReg <= '0;
    end else begin
      memReg <= memNext;
    end
  end
  assign bus.rdData = memReg.rd;
endmodule

// ===== hw/shp_parity.sv
// Odd parity per byte lane
`timescale 1ns/1ps
module shp_parity (
  // Data in
  input wire logic [31:0] data,
  // Parity out
  output logic [3:0] parity
);
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gLane
      assign parity[g] = ~(^data[g*8 +: 8]);
    end
  endgenerate
endmodule

// ===== hw/shp_host_port.sv
// Host bus port: strobes, lane decode, data drive and interrupt
`timescale 1ns/1ps
module shp_host_port (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bus width straps
  input wire logic [1:0] busMode,
  // Host control
  input wire logic chipSel_b,
  input wire logic hostReadStrobe_b,
  input wire logic hostWriteStrobe_b,
  input wire logic dmaGrantInput_b,
  input wire logic [1:0] addrHigh,
  input wire logic addrBit0OrLane2Enable,
  input wire logic addrBit1OrLane3Enable,
  input wire logic lane1Enable_b,
  input wire logic lane0OrHighByteEnable_b,
  // Data and parity pins
  input wire logic [31:0] dataIn,
  input wire logic [3:0] laneParityIn,
  output logic [31:0] dataOut,
  output logic [3:0] dataOe,
  output logic [3:0] laneParityBitsOut,
  output logic [3:0] laneParityOe,
  // Internal events and interrupt
  input wire logic [shp_pkg::SRC_W-1:0] intSources,
  output logic intReq,
  output logic parityErr
);
  typedef struct packed {
    shp_pkg::shp_state_t state;
    logic [31:0] dOut;
    logic [3:0] dOe;
    logic [3:0] pOe;
    logic [3:0] par;
    logic intr;
    logic pErr;
  } shp_port_st_t;

  shp_port_st_t stReg;
  shp_port_st_t stNext;
  shp_mem_if memBus();
  logic [3:0] wrPar;
  logic [3:0] rdPar;
  logic [3:0] lanes;
  logic [1:0] lowAddr;
  logic selected;
  logic [31:0] rdShift;
  logic [31:0] wrShift;

  shp_reg_mem uMem (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .bus(memBus.mem)
  );
  shp_parity uParW (
    .data(dataIn),
    .parity(wrPar)
  );
  shp_parity uParR (
    .data(rdShift),
    .parity(rdPar)
  );

  // Active lanes and low address by bus mode
  always_comb begin
    lanes = 4'h0;
    lowAddr = 2'h0;
    if (busMode == shp_pkg::MODE_32) begin
      lanes = {~addrBit1OrLane3Enable, ~addrBit0OrLane2Enable, ~lane1Enable_b,
               ~lane0OrHighByteEnable_b};
    end else if (busMode == shp_pkg::MODE_16) begin
      lowAddr = {addrBit1OrLane3Enable, 1'b0};
      if (!addrBit0OrLane2Enable && !lane0OrHighByteEnable_b) begin
        lanes = 4'h3;
      end else if (!addrBit0OrLane2Enable) begin
        lanes = 4'h1;
      end else if (!lane0OrHighByteEnable_b) begin
        lanes = 4'h2;
      end
    end else begin
      lowAddr = {addrBit1OrLane3Enable, addrBit0OrLane2Enable};
      lanes = 4'h1;
    end
  end

  // Chip select gates strobes; DMA grant overrides decode
  assign selected = !dmaGrantInput_b || !chipSel_b;
  always_comb begin
    if (!dmaGrantInput_b) begin
      memBus.addr = shp_pkg::FIFO_REG_IDX;
    end else begin
      memBus.addr = {addrHigh, lowAddr};
    end
  end

  // 8-bit mode copies the low data byte onto every lane; other modes pass data unchanged
  always_comb begin
    if (busMode == shp_pkg::MODE_8) begin
      wrShift = {4{dataIn[7:0]}};
    end else begin
      wrShift = dataIn;
    end
  end
  assign rdShift = memBus.rdData;
  assign memBus.wrData = wrShift;
  assign memBus.wrLane = (selected && !hostWriteStrobe_b && stReg.state != shp_pkg::SHP_WRITE)
                         ? lanes : 4'h0;

  always_comb begin
    stNext = stReg;
    stNext.intr = |intSources;
    stNext.pErr = 1'b0;
    case (stReg.state)
      shp_pkg::SHP_IDLE: begin
        stNext.dOe = 4'h0;
        stNext.pOe = 4'h0;
        if (selected && !hostReadStrobe_b) begin
          stNext.state = shp_pkg::SHP_READ;
        end else if (selected && !hostWriteStrobe_b) begin
          stNext.state = shp_pkg::SHP_WRITE;
          stNext.pErr = |((wrPar ^ laneParityIn) & lanes);
        end
      end
      shp_pkg::SHP_READ: begin
        stNext.dOut = rdShift;
        stNext.dOe = lanes;
        stNext.pOe = lanes;
        stNext.par = rdPar;
        if (!selected || hostReadStrobe_b) begin
          stNext.state = shp_pkg::SHP_IDLE;
          stNext.dOe = 4'h0;
          stNext.pOe = 4'h0;
        end
      end
      shp_pkg::SHP_WRITE: begin
        if (!selected || hostWriteStrobe_b) begin
          stNext.state = shp_pkg::SHP_IDLE;
        end
      end
      default: begin
        stNext.state = shp_pkg::SHP_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stReg <= '0;
    end else begin
      stReg <= stNext;
    end
  end

  assign dataOut = stReg.dOut;
  assign dataOe = stReg.dOe;
  assign laneParityBitsOut = stReg.par;
  assign laneParityOe = stReg.pOe;
  assign intReq = stReg.intr;
  assign parityErr = stReg.pErr;

  // Checks
  property p_int_follows;
    @(posedge sys_clk) disable iff (!rst_b) (|intSources) |=> intReq;
  endproperty
  a_int_follows: assert property (p_int_follows) else $error("irq missing");
  property p_no_drive_unsel;
    @(posedge sys_clk) disable iff (!rst_b)
      (chipSel_b && dmaGrantInput_b) |=> (dataOe == 4'h0);
  endproperty
  a_no_drive_unsel: assert property (p_no_drive_unsel) else $error("drive unselected");
  property p_no_write_unsel;
    @(posedge sys_clk) disable iff (!rst_b)
      (chipSel_b && dmaGrantInput_b) |-> (memBus.wrLane == 4'h0);
  endproperty
  a_no_write_unsel: assert property (p_no_write_unsel) else $error("write unselected");
  property p_dma_fifo;
    @(posedge sys_clk) disable iff (!rst_b)
      !dmaGrantInput_b |-> (memBus.addr == shp_pkg::FIFO_REG_IDX);
  endproperty
  a_dma_fifo: assert property (p_dma_fifo) else $error("dma not fifo");
  property p_p16_lanes;
    @(posedge sys_clk) disable iff (!rst_b)
      (busMode == shp_pkg::MODE_16) |-> (laneParityOe[3:2] == 2'b00);
  endproperty
  a_p16_lanes: assert property (p_p16_lanes) else $error("parity lane driven");
  property p_read_drive;
    @(posedge sys_clk) disable iff (!rst_b)
      (stReg.state == shp_pkg::SHP_READ && selected && !hostReadStrobe_b) |=> dataOe == $past(lanes);
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read lanes wrong");
  property p_write_lanes;
    @(posedge sys_clk) disable iff (!rst_b)
      (busMode == shp_pkg::MODE_16 && memBus.wrLane != 4'h0) |-> memBus.wrLane[3:2] == 2'b00;
  endproperty
  a_write_lanes: assert property (p_write_lanes) else $error("16-bit lane bad");
  property p_mode8_addr;
    @(posedge sys_clk) disable iff (!rst_b)
      (busMode == shp_pkg::MODE_8 && dmaGrantInput_b) |->
        memBus.addr == {addrHigh, addrBit1OrLane3Enable, addrBit0OrLane2Enable};
  endproperty
  a_mode8_addr: assert property (p_mode8_addr) else $error("addr decode bad");

  // Interrupt, address, data, lane, parity and drive checks
  property p_int_clear;
    @(posedge sys_clk) disable iff (!rst_b) !(|intSources) |=> !intReq;
  endproperty
  a_int_clear: assert property (p_int_clear) else $error("irq stuck");

  property p_read_data;
    @(posedge sys_clk) disable iff (!rst_b)
      (stReg.state == shp_pkg::SHP_READ && selected && !hostReadStrobe_b) |=>
        dataOut == $past(memBus.rdData);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");

  property p_write_once;
    @(posedge sys_clk) disable iff (!rst_b)
      (stReg.state == shp_pkg::SHP_WRITE) |-> (memBus.wrLane == 4'h0);
  endproperty
  a_write_once: assert property (p_write_once) else $error("second write");

  property p_addr_high;
    @(posedge sys_clk) disable iff (!rst_b)
      dmaGrantInput_b |-> (memBus.addr[3:2] == addrHigh);
  endproperty
  a_addr_high: assert property (p_addr_high) else $error("high address lost");

  property p_mode32_lanes;
    @(posedge sys_clk) disable iff (!rst_b)
      (busMode == shp_pkg::MODE_32 && selected && !hostWriteStrobe_b &&
        stReg.state == shp_pkg::SHP_IDLE) |->
        memBus.wrLane == ~{addrBit1OrLane3Enable, addrBit0OrLane2Enable, lane1Enable_b,
          lane0OrHighByteEnable_b};
  endproperty
  a_mode32_lanes: assert property (p_mode32_lanes) else $error("byte enables lost");

  property p_mode32_addr;
    @(posedge sys_clk) disable iff (!rst_b)
      (busMode == shp_pkg::MODE_32 && dmaGrantInput_b) |-> (memBus.addr[1:0] == 2'b00);
  endproperty
  a_mode32_addr: assert property (p_mode32_addr) else $error("wide addr bad");

  property p_mode8_lane;
    @(posedge sys_clk) disable iff (!rst_b)
      (busMode == shp_pkg::MODE_8 && memBus.wrLane != 4'h0) |-> (memBus.wrLane == 4'h1);
  endproperty
  a_mode8_lane: assert property (p_mode8_lane) else $error("narrow lane bad");

  property p_upper_read;
    @(posedge sys_clk) disable iff (!rst_b)
      (busMode == shp_pkg::MODE_16 && !lane0OrHighByteEnable_b && selected &&
        !hostReadStrobe_b && stReg.state == shp_pkg::SHP_READ) |=> dataOe[1];
  endproperty
  a_upper_read: assert property (p_upper_read) else $error("upper byte not driven");

  property p_wdata16;
    @(posedge sys_clk) disable iff (!rst_b)
      (busMode == shp_pkg::MODE_16) |-> (memBus.wrData[15:0] == dataIn[15:0]);
  endproperty
  a_wdata16: assert property (p_wdata16) else $error("halfword data moved");

  property p_idle_unsel;
    @(posedge sys_clk) disable iff (!rst_b)
      (stReg.state == shp_pkg::SHP_IDLE && !selected) |=>
        (stReg.state == shp_pkg::SHP_IDLE);
  endproperty
  a_idle_unsel: assert property (p_idle_unsel) else $error("access unselected");

  property p_wdata32;
    @(posedge sys_clk) disable iff (!rst_b)
      (busMode == shp_pkg::MODE_32) |-> (memBus.wrData == dataIn);
  endproperty
  a_wdata32: assert property (p_wdata32) else $error("word data moved");

  property p_perr_pulse;
    @(posedge sys_clk) disable iff (!rst_b) parityErr |=> !parityErr;
  endproperty
  a_perr_pulse: assert property (p_perr_pulse) else $error("parity flag stuck");

  // Parity is checked only where the lane is driven; idle lanes keep stale values
  genvar gp;
  generate
    for (gp = 0; gp < shp_pkg::LANES; gp++) begin : gParChk
      property p_lane_par;
        @(posedge sys_clk) disable iff (!rst_b)
          laneParityOe[gp] |-> (laneParityBitsOut[gp] == ~^dataOut[gp*8 +: 8]);
      endproperty
      a_lane_par: assert property (p_lane_par) else $error("lane parity wrong");
    end
  endgenerate

  property p_p8_lanes;
    @(posedge sys_clk) disable iff (!rst_b)
      (busMode == shp_pkg::MODE_8) |-> (laneParityOe[3:1] == 3'b000);
  endproperty
  a_p8_lanes: assert property (p_p8_lanes) else $error("narrow parity driven");

  property p_dma_read;
    @(posedge sys_clk) disable iff (!rst_b)
      (!dmaGrantInput_b && chipSel_b && !hostReadStrobe_b &&
        stReg.state == shp_pkg::SHP_IDLE) |=> (stReg.state == shp_pkg::SHP_READ);
  endproperty
  a_dma_read: assert property (p_dma_read) else $error("grant read lost");

  property p_oe_pair;
    @(posedge sys_clk) disable iff (!rst_b) laneParityOe == dataOe;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("parity drive split");

  property p_no_drive_write;
    @(posedge sys_clk) disable iff (!rst_b)
      (stReg.state == shp_pkg::SHP_WRITE) |-> (dataOe == 4'h0);
  endproperty
  a_no_drive_write: assert property (p_no_drive_write) else $error("drive in write");
endmodule

// ===== verif/shp_host_cpu.sv
// Host CPU model that runs register cycles on the port
`timescale 1ns/1ps
module shp_host_cpu (
  // Clock
  input wire logic sysClk,
  // Active low strobes and selects: read, write, chip select, DMA grant
  output logic [3:0] ctlB,
  output logic [1:0] addrHigh,
  output logic [3:0] laneEnB,
  // Pins as seen by the port
  output logic [31:0] dataIn,
  output logic [3:0] parIn,
  input wire logic [31:0] dataOut,
  input wire logic [3:0] dataOe,
  input wire logic [3:0] parOut,
  input wire logic [3:0] parOe,
  input wire logic parErr
);
  logic [31:0] hostD = 32'h0;
  logic [3:0] hostP = 4'h0;
  initial begin
    ctlB = 4'hf;
    addrHigh = 2'h0;
    laneEnB = 4'hf;
  end
  // Released lanes show the inverse of the last value, so a stale copy never reads back
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      dataIn[8*i+:8] = dataOe[i] ? dataOut[8*i+:8] : hostD[8*i+:8];
    end
  end
  assign parIn = hostP;
  // One access; request held until the answer is taken, then released
  task automatic acc(input logic [3:0] c, input logic [1:0] a, input logic [3:0] e,
      input logic [31:0] d, input logic [3:0] p, output logic [31:0] q,
      output logic [7:0] oe, output logic [3:0] qp, output logic pe);
    @(posedge sysClk);
    #1;
    ctlB = c;
    addrHigh = a;
    laneEnB = e;
    hostD = d;
    hostP = p;
    @(posedge sysClk);
    #1;
    pe = parErr;
    repeat (3) @(posedge sysClk);
    #1;
    q = dataOut;
    oe = {parOe, dataOe};
    qp = parOut;
    ctlB = 4'hf;
    hostD = ~hostD;
    hostP = ~hostP;
    @(posedge sysClk);
    #1;
  endtask
endmodule

// ===== verif/test_scsi_ctrl_host_bus_port.sv
// Self-checking bench for the host bus port
`timescale 1ns/1ps
module test_scsi_ctrl_host_bus_port;
  localparam logic [3:0] RD = 4'h5, WR = 4'h9, RN = 4'h7, WN = 4'hb, DR = 4'h6, DW = 4'ha;
  logic sysClk = 1'b0;
  logic rstB = 1'b0;
  logic [1:0] busMode = shp_pkg::MODE_32;
  logic [shp_pkg::SRC_W-1:0] intSources = '0;
  logic [3:0] ctlB, laneEnB, dataOe, parIn, parOut, parOe, qp, e;
  logic [1:0] addrHigh, a, m;
  logic [31:0] dataIn, dataOut, q, d, seed = 32'h1559238e;
  logic [7:0] oe;
  logic intReq, parityErr, pe;
  logic [31:0] mem [4];
  int failures = 0;
  int checksDone = 0;
  always #25 sysClk = ~sysClk;
  shp_host_port dut (.sys_clk(sysClk), .rst_b(rstB), .busMode(busMode),
    .chipSel_b(ctlB[1]), .hostReadStrobe_b(ctlB[3]), .hostWriteStrobe_b(ctlB[2]),
    .dmaGrantInput_b(ctlB[0]), .addrHigh(addrHigh), .addrBit0OrLane2Enable(laneEnB[2]),
    .addrBit1OrLane3Enable(laneEnB[3]), .lane1Enable_b(laneEnB[1]),
    .lane0OrHighByteEnable_b(laneEnB[0]), .dataIn(dataIn), .laneParityIn(parIn),
    .dataOut(dataOut), .dataOe(dataOe), .laneParityBitsOut(parOut), .laneParityOe(parOe),
    .intSources(intSources), .intReq(intReq), .parityErr(parityErr));
  shp_host_cpu host (.sysClk(sysClk), .ctlB(ctlB), .addrHigh(addrHigh), .laneEnB(laneEnB),
    .dataIn(dataIn), .parIn(parIn), .dataOut(dataOut), .dataOe(dataOe), .parOut(parOut),
    .parOe(parOe), .parErr(parityErr));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Odd parity per byte lane
  function automatic logic [3:0] par(input logic [31:0] v);
    return {~^v[31:24], ~^v[23:16], ~^v[15:8], ~^v[7:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d, failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sysClk);
    failures++;
    summarize();
  end
  initial begin
    for (int i = 0; i < 4; i++) mem[i] = shp_pkg::REG_RESET;
    repeat (5) @(posedge sysClk);
    #1;
    rstB = 1'b1;
    chk(dataOe, 4'h0);
    host.acc(WR, 2'h0, 4'h0, 32'h1, ~par(32'h1), q, oe, qp, pe);
    chk(pe, 1'b1);
    // Grant overrides chip select and address
    host.acc(DW, 2'h2, 4'h0, seed, par(seed), q, oe, qp, pe);
    mem[0] = seed;
    chk(pe, 1'b0);
    for (int n = 0; n < 14; n++) begin
      seed = lfsr(seed);
      a = seed[1:0];
      e = seed[5:2];
      d = lfsr(seed);
      host.acc(WR, a, e, d, par(d), q, oe, qp, pe);
      chk(pe, 1'b0);
      for (int j = 0; j < 4; j++) if (!e[j]) mem[a][8*j+:8] = d[8*j+:8];
      a = seed[7:6];
      host.acc(RD, a, 4'h0, 32'h0, 4'h0, q, oe, qp, pe);
      chk(q, mem[a]);
      chk(oe, 8'hff);
      chk(qp, par(mem[a]));
      chk(dataOe, 4'h0);
    end
    // Strobes without chip select are ignored
    host.acc(WN, 2'h1, 4'h0, ~mem[1], 4'h0, q, oe, qp, pe);
    host.acc(RN, 2'h1, 4'h0, 32'h0, 4'h0, q, oe, qp, pe);
    chk(oe, 8'h00);
    host.acc(RD, 2'h1, 4'h0, 32'h0, 4'h0, q, oe, qp, pe);
    chk(q, mem[1]);
    host.acc(DR, 2'h3, 4'h0, 32'h0, 4'h0, q, oe, qp, pe);
    chk(q, mem[0]);
    busMode = shp_pkg::MODE_16;
    // A0 and upper enable are never both high from the host
    for (int i = 0; i < 3; i++) begin
      m = {~i[0], ~i[1]};
      host.acc(RD, 2'h1, {1'b0, i[1], 1'b1, i[0]}, 32'h0, 4'h0, q, oe, qp, pe);
      chk(oe, {2'b00, m, 2'b00, m});
      chk(q[15:0] & {{8{m[1]}}, {8{m[0]}}}, mem[1][15:0] & {{8{m[1]}}, {8{m[0]}}});
      chk(qp & {2'b00, m}, par(mem[1]) & {2'b00, m});
    end
    busMode = shp_pkg::MODE_8;
    d = lfsr(seed);
    host.acc(WR, 2'h1, 4'h0, d, par(d), q, oe, qp, pe);
    mem[1][7:0] = d[7:0];
    chk(pe, 1'b0);
    host.acc(RD, 2'h1, 4'h0, 32'h0, 4'h0, q, oe, qp, pe);
    chk(oe, 8'h11);
    chk(q[7:0], mem[1][7:0]);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      intSources = i[0] ? seed[shp_pkg::SRC_W-1:0] : '0;
      repeat (2) @(posedge sysClk);
      #1;
      chk(intReq, |intSources);
    end
    summarize();
  end
endmodule
